// File: src/ppi_top.sv
/*
 * Parallel pixel front end with general output routing.
 * Pixel capture runs on pclk; registers, output routing and strap
 * capture run on clk behind an AHB-Lite slave. Assumes pclk and clk are
 * unrelated, and that ce stays high while a bus transfer is in flight.
 */
module ppi_top #(
   parameter int CLOCK_OUT_HALF = ppi_pkg::PPI_CLOCK_OUT_HALF
) (
   input wire logic clk, // system clock, 250 MHz
   input wire logic rst, // async reset, active high
   input wire logic ce, // clock enable, freezes clk-domain registers other than the synchronisers when low
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [31:0] hrdata, // ahb read data
   input wire logic power_down_n, // power-down pin, low = down
   input wire logic osc_strap, // strap, high = external oscillator
   output logic pll_enable, // pll runs while high
   input wire logic [ppi_pkg::PPI_NGPO-1:0] remote_gpio, // remote values
   output logic [2:0] general_output, // outputs 0..2, 2 = clock_out
   output logic general_output_3_out, // output 3 drive value
   output logic general_output_3_oe, // output 3 enable, high = drive
   input wire logic general_output_3_in, // pin 3 level, clock_in
   input wire logic pclk, // pixel clock from sensor
   input wire logic [ppi_pkg::PPI_DW-1:0] pixel_data_in, // pixel word
   input wire logic line_sync_in, // line sync from sensor
   input wire logic frame_sync_in, // frame sync from sensor
   output logic [ppi_pkg::PPI_DW-1:0] pixel_data_out, // captured word
   output logic line_sync_out, // captured line sync
   output logic frame_sync_out, // captured frame sync
   output logic sample_valid // captured sample is live
);
   import ppi_pkg::*;

   // clk domain state
   logic edge_sel, next_edge_sel;
   ppi_fmt_t fmt, next_fmt;
   logic [PPI_GPO_W-1:0] gpo_cfg, next_gpo_cfg;
   logic strap_osc, next_strap_osc;
   logic strap_taken, next_strap_taken;
   logic dp_valid, next_dp_valid;
   logic dp_wr, next_dp_wr;
   logic [7:0] dp_idx, next_dp_idx;
   logic [31:0] next_hrdata;
   logic next_hreadyout;
   logic next_pll_enable;
   logic [7:0] div_cnt, next_div_cnt;
   logic clk_out_q, next_clk_out_q;
   logic [2:0] next_general_output;
   logic next_g3_out, next_g3_oe;
   logic [PPI_SMP_W-1:0] smp_word, next_smp_word;
   logic req_seen, next_req_seen;

   logic pdn_s, strap_s, clock_in_s, req_s;
   logic [PPI_NGPO-1:0] remote_s;

   // pclk domain state
   logic [PPI_SMP_W-1:0] neg_smp;
   logic [PPI_SMP_W-1:0] smp_q, next_smp_q;
   logic next_valid;
   logic [PPI_SMP_W-1:0] smp_hold, next_smp_hold;
   logic req_tgl, next_req_tgl;
   logic edge_p, pwr_p, ack_s;
   logic [1:0] fmt_p;

   ppi_sync #(.W(PPI_NGPO + 3)) u_sync_pins (
      .clk(clk),
      .rst(rst),
      .d({power_down_n, osc_strap, general_output_3_in, remote_gpio}),
      .q({pdn_s, strap_s, clock_in_s, remote_s})
   );

   ppi_sync #(.W(1)) u_sync_req (
      .clk(clk),
      .rst(rst),
      .d(req_tgl),
      .q(req_s)
   );

   // config is quasi-static, so a plain level crossing is enough
   ppi_sync #(.W(4)) u_sync_cfg (
      .clk(pclk),
      .rst(rst),
      .d({edge_sel, fmt, pdn_s}),
      .q({edge_p, fmt_p, pwr_p})
   );

   ppi_sync #(.W(1)) u_sync_ack (
      .clk(pclk),
      .rst(rst),
      .d(req_seen),
      .q(ack_s)
   );

   function automatic logic [31:0] rd_word(
      input logic [7:0] idx,
      input logic e,
      input ppi_fmt_t f,
      input logic [PPI_GPO_W-1:0] g
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      case (idx)
         PPI_REG_CFG_IDX: begin
            w[PPI_CFG_EDGE_BIT] = e;
            w[PPI_CFG_FMT_LSB +: 2] = f;
         end
         PPI_REG_GPO_IDX: w[PPI_GPO_W-1:0] = g;
         PPI_REG_STAT_IDX: begin
            w[PPI_STAT_OSC_BIT] = strap_osc;
            w[PPI_STAT_PWR_BIT] = pdn_s;
            w[PPI_STAT_CLOCK_IN_BIT] = clock_in_s;
            w[PPI_STAT_REMOTE_LSB +: PPI_NGPO] = remote_s;
         end
         PPI_REG_SMP_IDX: w[PPI_SMP_W-1:0] = smp_word;
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   logic [PPI_NGPO-1:0] route;
   logic clk_mode;

   always_comb begin
      next_edge_sel = edge_sel;
      next_fmt = fmt;
      next_gpo_cfg = gpo_cfg;
      next_strap_osc = strap_osc;
      next_strap_taken = strap_taken;
      next_hreadyout = 1'b1;
      next_smp_word = smp_word;
      next_req_seen = req_seen;
      next_div_cnt = div_cnt;
      next_clk_out_q = clk_out_q;
      // data phase of a write
      if (dp_valid && dp_wr) begin
         case (dp_idx)
            PPI_REG_CFG_IDX: begin
               next_edge_sel = hwdata[PPI_CFG_EDGE_BIT];
               next_fmt = ppi_fmt_t'(hwdata[PPI_CFG_FMT_LSB +: 2]);
            end
            PPI_REG_GPO_IDX: next_gpo_cfg = hwdata[PPI_GPO_W-1:0];
            default: ;
         endcase
      end
      // address phase; unmapped words decode to an index that reads zero
      next_dp_valid = hsel && hready && htrans[1];
      next_dp_wr = hwrite;
      next_dp_idx = (haddr[31:10] == 22'h0 && haddr[1:0] == 2'b00) ?
                    haddr[9:2] : PPI_REG_NONE_IDX;
      // read mux sees a write still in its data phase
      if (next_dp_valid && !hwrite) begin
         next_hrdata = rd_word(next_dp_idx, next_edge_sel, next_fmt,
                               next_gpo_cfg);
      end else begin
         next_hrdata = 32'h0000_0000;
      end
      // strap caught once per power-up, after reset is released
      if (pdn_s && !strap_taken) begin
         next_strap_osc = strap_s;
         next_strap_taken = 1'b1;
      end
      // sample word crossing: hold register is stable while req differs
      if (req_s != req_seen) begin
         next_smp_word = smp_hold;
         next_req_seen = req_s;
      end
      // general output routing
      for (int i = 0; i < PPI_NGPO; i++) begin
         route[i] = gpo_cfg[PPI_GPO_SRC_LSB + i] ? remote_s[i] :
                    gpo_cfg[PPI_GPO_LOCAL_LSB + i];
      end
      clk_mode = strap_osc && gpo_cfg[PPI_GPO_CLKPIN_BIT];
      if (clk_mode) begin
         if (div_cnt == 8'(CLOCK_OUT_HALF - 1)) begin
            next_div_cnt = 8'h00;
            next_clk_out_q = !clk_out_q;
         end else begin
            next_div_cnt = div_cnt + 8'h01;
         end
      end else begin
         next_div_cnt = 8'h00;
         next_clk_out_q = 1'b0;
      end
      next_general_output = {clk_mode ? clk_out_q : route[2],
                             route[1:0]};
      next_g3_out = route[3];
      // pin 3 released so the oscillator can drive it
      next_g3_oe = !clk_mode;
      next_pll_enable = pdn_s;
      // power-down drops all programmed settings
      if (!pdn_s) begin
         next_edge_sel = PPI_EDGE_RST;
         next_fmt = PPI_FMT_RST;
         next_gpo_cfg = PPI_GPO_RST;
         next_strap_osc = 1'b0;
         next_strap_taken = 1'b0;
         next_general_output = 3'b000;
         next_g3_out = 1'b0;
         next_g3_oe = 1'b0;
         next_div_cnt = 8'h00;
         next_clk_out_q = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         edge_sel <= PPI_EDGE_RST;
         fmt <= PPI_FMT_RST;
         gpo_cfg <= PPI_GPO_RST;
         strap_osc <= 1'b0;
         strap_taken <= 1'b0;
         dp_valid <= 1'b0;
         dp_wr <= 1'b0;
         dp_idx <= PPI_REG_NONE_IDX;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= PPI_HRESP_OKAY;
         pll_enable <= 1'b0;
         div_cnt <= 8'h00;
         clk_out_q <= 1'b0;
         general_output <= 3'b000;
         general_output_3_out <= 1'b0;
         general_output_3_oe <= 1'b0;
         smp_word <= '0;
         req_seen <= 1'b0;
      end else if (ce) begin
         edge_sel <= next_edge_sel;
         fmt <= next_fmt;
         gpo_cfg <= next_gpo_cfg;
         strap_osc <= next_strap_osc;
         strap_taken <= next_strap_taken;
         dp_valid <= next_dp_valid;
         dp_wr <= next_dp_wr;
         dp_idx <= next_dp_idx;
         hrdata <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp <= PPI_HRESP_OKAY;
         pll_enable <= next_pll_enable;
         div_cnt <= next_div_cnt;
         clk_out_q <= next_clk_out_q;
         general_output <= next_general_output;
         general_output_3_out <= next_g3_out;
         general_output_3_oe <= next_g3_oe;
         smp_word <= next_smp_word;
         req_seen <= next_req_seen;
      end
   end

   // falling-edge copy; rising capture retimes it half a cycle later
   always_ff @(negedge pclk or posedge rst) begin
      if (rst) begin
         neg_smp <= '0;
      end else begin
         neg_smp <= {frame_sync_in, line_sync_in, pixel_data_in};
      end
   end

   logic [PPI_SMP_W-1:0] raw;

   always_comb begin
      // syncs and word taken in one register, never split
      raw = edge_p ? {frame_sync_in, line_sync_in, pixel_data_in} :
            neg_smp;
      // sensor keeps 10-bit sync spacing; no filtering needed
      case (fmt_p)
         PPI_FMT_10: raw[11:10] = 2'b00;
         default: ; // all bits and raw syncs pass
      endcase
      next_smp_q = pwr_p ? raw : '0;
      next_valid = pwr_p;
      next_smp_hold = smp_hold;
      next_req_tgl = req_tgl;
      // new snapshot only once clk side has acknowledged the last
      if (pwr_p && ack_s == req_tgl) begin
         next_smp_hold = raw;
         next_req_tgl = !req_tgl;
      end
   end

   always_ff @(posedge pclk or posedge rst) begin
      if (rst) begin
         smp_q <= '0;
         sample_valid <= 1'b0;
         smp_hold <= '0;
         req_tgl <= 1'b0;
      end else begin
         smp_q <= next_smp_q;
         sample_valid <= next_valid;
         smp_hold <= next_smp_hold;
         req_tgl <= next_req_tgl;
      end
   end

   assign pixel_data_out = smp_q[PPI_DW-1:0];
   assign line_sync_out = smp_q[PPI_SMP_LINE_BIT];
   assign frame_sync_out = smp_q[PPI_SMP_FRAME_BIT];

endmodule

// File: src/ppi_pkg.sv
/*
 * Shared constants for the parallel pixel input and general output block:
 * register indices, field positions, reset values, pixel formats and
 * bus encodings.
 * Assumes a 32-bit AHB-Lite register bus; byte address = 4 * index.
 */
package ppi_pkg;

   localparam int PPI_DW = 12;
   localparam int PPI_NGPO = 4;

   // register indices (byte address is four times the index)
   localparam logic [7:0] PPI_REG_CFG_IDX = 8'h03;
   localparam logic [7:0] PPI_REG_GPO_IDX = 8'h04;
   localparam logic [7:0] PPI_REG_STAT_IDX = 8'h05;
   localparam logic [7:0] PPI_REG_SMP_IDX = 8'h06;
   localparam logic [7:0] PPI_REG_NONE_IDX = 8'hff;

   // configuration register fields
   localparam int PPI_CFG_EDGE_BIT = 0;
   localparam int PPI_CFG_FMT_LSB = 1;

   // general output register fields
   localparam int PPI_GPO_LOCAL_LSB = 0;
   localparam int PPI_GPO_SRC_LSB = 4;
   localparam int PPI_GPO_CLKPIN_BIT = 8;
   localparam int PPI_GPO_W = 9;

   // status register fields
   localparam int PPI_STAT_OSC_BIT = 0;
   localparam int PPI_STAT_PWR_BIT = 1;
   localparam int PPI_STAT_CLOCK_IN_BIT = 2;
   localparam int PPI_STAT_REMOTE_LSB = 3;

   // sample register fields
   localparam int PPI_SMP_LINE_BIT = 12;
   localparam int PPI_SMP_FRAME_BIT = 13;
   localparam int PPI_SMP_W = 14;

   typedef enum logic [1:0] {
      PPI_FMT_10 = 2'b00,
      PPI_FMT_12HF = 2'b01,
      PPI_FMT_12LF = 2'b10
   } ppi_fmt_t;

   // reset values
   localparam logic PPI_EDGE_RST = 1'b1;
   localparam ppi_fmt_t PPI_FMT_RST = PPI_FMT_10;
   localparam logic [PPI_GPO_W-1:0] PPI_GPO_RST = 9'h000;

   // clock_out half period in clk cycles
   localparam int PPI_CLOCK_OUT_HALF = 2;

   localparam logic PPI_HRESP_OKAY = 1'b0;

endpackage

// File: src/ppi_sync.sv
/*
 * Two-flop level synchroniser, W bits wide, reset to zero.
 * Assumes each bit is a level that stays put long enough to be seen;
 * multi-bit words must be quasi-static or guarded by a handshake.
 */
module ppi_sync #(
   parameter int W = 1
) (
   input wire logic clk, // destination clock
   input wire logic rst, // async reset, active high
   input wire logic [W-1:0] d, // asynchronous level in
   output logic [W-1:0] q // synchronised level out
);
   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// File: tb/ppi_chk.sv
/* Checker for ppi_top: bus answer, power-down and clock-out timing.
   Bound to every ppi_top instance; sees its ports only. */
module ppi_chk
   import ppi_pkg::*;
#(
   parameter int CLOCK_OUT_HALF = 2
) (
   input wire logic clk, // system clock
   input wire logic rst, // async reset
   input wire logic pclk, // pixel clock
   input wire logic hsel, // slave select
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic hready, // bus ready
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // response
   input wire logic [31:0] hrdata, // read data
   input wire logic power_down_n, // power pin
   input wire logic pll_enable, // pll on
   input wire logic [2:0] general_output, // outputs 0..2
   input wire logic general_output_3_out, // output 3 value
   input wire logic general_output_3_oe, // output 3 enable
   input wire logic [PPI_DW-1:0] pixel_data_out, // pixel word
   input wire logic line_sync_out, // line sync
   input wire logic frame_sync_out, // frame sync
   input wire logic sample_valid // sample live
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] hi_cnt;

   // length of the current high phase of output 2
   always_ff @(posedge clk or posedge rst)
      if (rst)
         hi_cnt <= 8'h0;
      else
         hi_cnt <= general_output[2] ? hi_cnt + 8'h1 : 8'h0;

   a_resp_okay: assert property (@(posedge clk) disable iff (rst)
      hreadyout && hresp == PPI_HRESP_OKAY) else $error("bus answer");
   a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
      !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
      else $error("read data outside data phase");
   a_pll_rise: assert property (@(posedge clk) disable iff (rst)
      power_down_n [*4] |=> pll_enable) else $error("pll not started");
   a_pll_fall: assert property (@(posedge clk) disable iff (rst)
      !power_down_n [*4] |=> !pll_enable) else $error("pll not stopped");
   a_down_quiet: assert property (@(posedge clk) disable iff (rst)
      !pll_enable [*2] |-> general_output == 3'h0 && !general_output_3_oe
      && !general_output_3_out) else $error("outputs live when down");
   a_clock_out_half: assert property (@(posedge clk) disable iff (rst)
      $fell(general_output[2]) && !general_output_3_oe && pll_enable
      |-> hi_cnt == CLOCK_OUT_HALF) else $error("clock out half period");
   a_pix_quiet: assert property (@(posedge pclk) disable iff (rst)
      !sample_valid [*2] |-> pixel_data_out == '0 && !line_sync_out
      && !frame_sync_out) else $error("pixel outputs live when down");
   a_valid_power: assert property (@(posedge pclk) disable iff (rst)
      $rose(sample_valid) |-> pll_enable) else $error("valid unpowered");

   c_pll_off: cover property (@(posedge clk) $fell(pll_enable));
   c_clk_mode: cover property (@(posedge clk) $fell(general_output_3_oe));
   c_valid: cover property (@(posedge pclk) $rose(sample_valid));
endmodule

bind ppi_top ppi_chk #(.CLOCK_OUT_HALF(CLOCK_OUT_HALF)) chk (.clk(clk),
   .rst(rst), .pclk(pclk), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .power_down_n(power_down_n), .pll_enable(pll_enable),
   .general_output(general_output),
   .general_output_3_out(general_output_3_out),
   .general_output_3_oe(general_output_3_oe),
   .pixel_data_out(pixel_data_out), .line_sync_out(line_sync_out),
   .frame_sync_out(frame_sync_out), .sample_valid(sample_valid));

// File: tb/ppi_sensor.sv
/* Image sensor model: free-running pixel clock, random pixels and syncs.
   Launches on the edge the block does not sample, so a wrong capture
   edge shifts the stream by one sample. */
module ppi_sensor (
   output logic pclk, // pixel clock, 32 ns
   input wire logic fmt10, // 10-bit format in use
   input wire logic launch_fall, // launch on falling edge
   output logic [11:0] data, // pixel word
   output logic line, // line sync
   output logic frame // frame sync
);
   timeunit 1ns;
   timeprecision 100ps;
   int seed = 85187;
   int gap = 0;
   logic [31:0] r;

   initial begin
      pclk = 0;
      data = 0;
      line = 0;
      frame = 0;
      #1.3;
      forever #16 pclk = ~pclk;
   end

   task automatic step();
      r = $random(seed);
      data <= r[11:0];
      gap++;
      if (!fmt10 || gap >= 10) begin
         if (r[12])
            line <= ~line;
         if (r[13])
            frame <= ~frame;
         if (r[12] || r[13])
            gap = 0;
      end
   endtask

   always @(posedge pclk)
      if (!launch_fall)
         step();
   always @(negedge pclk)
      if (launch_fall)
         step();
endmodule

// File: tb/ppi_top_tb.sv
/* Self-checking bench for ppi_top: bus master, sensor model, output and
   pixel monitors. Assumes ppi_sensor and the bound checker. */
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ppi_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ppi_pkg::*;
   localparam int HALF = PPI_CLOCK_OUT_HALF;
   logic clk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, power_down_n = 1;
   logic osc_strap = 0, fmt10 = 1, launch_fall = 0, rd_dp = 0, pix_on = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2, general_output;
   logic [3:0] remote_gpio = 0;
   logic hreadyout, hresp, pll_enable, go3_out, go3_oe, pclk;
   logic [11:0] pix_in, pix_out, mask = 12'h3ff;
   logic ls_in, fs_in, ls_out, fs_out, valid;
   int failures = 0, tests_run = 0, seed = 85187;
   logic [31:0] bq[$], exp_rd;
   logic [31:0] cfgs[7] = '{32'h3, 32'h5, 32'h7, 32'h4, 32'h2, 32'h1,
      32'h0};
   logic [14:0] exp_px;
   logic [4:0] exp_go;
   logic [4:0] gq[$];
   logic [14:0] pq[$];
   event go_ev;
   wire hready = hreadyout;
   wire go3_in = go3_oe ? go3_out : 1'b0; // board pull-down on pin 3

   always #2 clk = ~clk;

   ppi_top #(.CLOCK_OUT_HALF(HALF)) uut (
      .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .power_down_n(power_down_n),
      .osc_strap(osc_strap), .pll_enable(pll_enable),
      .remote_gpio(remote_gpio), .general_output(general_output),
      .general_output_3_out(go3_out), .general_output_3_oe(go3_oe),
      .general_output_3_in(go3_in), .pclk(pclk), .pixel_data_in(pix_in),
      .line_sync_in(ls_in), .frame_sync_in(fs_in), .pixel_data_out(pix_out),
      .line_sync_out(ls_out), .frame_sync_out(fs_out), .sample_valid(valid));

   ppi_sensor sensor (.pclk(pclk), .fmt10(fmt10), .launch_fall(launch_fall),
      .data(pix_in), .line(ls_in), .frame(fs_in));

   always @(posedge clk) begin
      if (rd_dp && hready) begin
         exp_rd = bq.pop_front();
         `CHK(hrdata, exp_rd)
      end
      rd_dp <= hsel && hready && htrans[1] && !hwrite;
   end
   always @(posedge pclk)
      if (pix_on)
         pq.push_back({1'b1, fs_in, ls_in, pix_in & mask});
   always @(negedge pclk)
      if (pix_on && pq.size() > 0) begin
         exp_px = pq.pop_front();
         `CHK({valid, fs_out, ls_out, pix_out}, exp_px)
      end
   always @(go_ev) begin
      exp_go = gq.pop_front();
      `CHK({go3_oe, go3_out, general_output}, exp_go)
   end

   task automatic complete_run();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wait_rdy();
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         failures++;
         complete_run();
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      hsel <= 1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic rd(input logic [31:0] a, e);
      bq.push_back(e);
      bus(0, a, 32'h0);
   endtask

   task automatic expect_go(input logic [4:0] e);
      repeat (8) @(posedge clk);
      gq.push_back(e);
      -> go_ev;
   endtask

   // edge select crosses domains: let it settle before checking
   task automatic pix_run(input logic [31:0] cfg);
      bus(1, 32'h0c, cfg);
      fmt10 <= cfg[2:1] == 2'b00;
      launch_fall <= cfg[0];
      mask <= cfg[2:1] == 2'b00 ? 12'h3ff : 12'hfff;
      repeat (12) @(posedge pclk);
      @(negedge pclk);
      pq.delete();
      pix_on = 1;
      repeat (30) @(posedge pclk);
      @(negedge pclk);
      pix_on = 0;
   endtask

   initial begin
      logic [8:0] g;
      logic [3:0] sel;
      logic last;
      int n;
      repeat (2) @(posedge clk);
      rst <= 0;
      remote_gpio <= 4'($random(seed));
      repeat (5) @(posedge clk);
      bus(1, 32'h40, 32'hffffffff);
      rd(32'h0c, 32'h1);
      rd(32'h10, 32'h0);
      rd(32'h40, 32'h0);
      rd(32'h14, {25'h0, remote_gpio, 3'b010});
      foreach (cfgs[i])
         pix_run(cfgs[i]);
      repeat (6) begin
         g = 9'($random(seed));
         g[8] = 0;
         remote_gpio <= 4'($random(seed));
         bus(1, 32'h10, {23'h0, g});
         rd(32'h10, {23'h0, g});
         sel = (g[7:4] & remote_gpio) | (~g[7:4] & g[3:0]);
         expect_go({1'b1, sel});
      end
      bus(1, 32'h14, 32'hffffffff);
      rd(32'h14, {25'h0, remote_gpio, sel[3], 2'b10});
      power_down_n <= 0;
      expect_go(5'h0);
      repeat (20) @(posedge clk);
      osc_strap <= 1;
      power_down_n <= 1;
      repeat (8) @(posedge clk);
      rd(32'h0c, 32'h1);
      rd(32'h10, 32'h0);
      rd(32'h14, {25'h0, remote_gpio, 3'b011});
      bus(1, 32'h10, 32'h100);
      repeat (8) @(posedge clk);
      n = 0;
      last = general_output[2];
      repeat (40) begin
         @(posedge clk);
         n += int'(general_output[2] && !last);
         last = general_output[2];
      end
      `CHK(n, 40 / (2 * HALF))
      `CHK(go3_oe, 1'b0)
      complete_run();
   end
endmodule
